// >>> hw/loop_brake_ctrl.sv
// Loop selection, open-loop auto-brake and brake-before-standby control
module loop_brake_ctrl (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst_n,
  input  wire logic                                  i_ce,
  input  wire loop_brake_pkg::reg_req_t              i_req,
  output logic [loop_brake_pkg::REG_W-1:0]           o_reg_rdata,
  output logic                                       o_reg_rvalid,
  input  wire logic                                  i_play_valid,
  input  wire logic signed [loop_brake_pkg::PLAY_W-1:0] i_play_data,
  input  wire logic                                  i_playing,
  input  wire logic                                  i_slope_big,
  input  wire logic                                  i_timer_idle,
  input  wire logic                                  i_trigger_or_irq_pin,
  input  wire logic                                  i_level_mode,
  input  wire logic                                  i_wake,
  input  wire logic                                  i_motion,
  input  wire logic                                  i_brake_done,
  output loop_brake_pkg::loop_sel_t                  o_loop,
  output logic                                       o_brake,
  output logic                                       o_standby
);
  import loop_brake_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [REG_W-1:0] ctrl_r;
  wire              wr_hit;
  wire              rd_hit;

  // Both request kinds decode the one control address
  function automatic logic addr_match(input logic [7:0] addr);
    return addr == LOOP_BRAKE_ADDR;
  endfunction : addr_match

  assign wr_hit = i_req.wr && addr_match(i_req.addr);
  assign rd_hit = i_req.rd && addr_match(i_req.addr);

  // All bits store as written; the reserved pair feeds nothing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= LOOP_BRAKE_RESET; // [R2] [R5] [R11] [R12]
    end else if (i_ce && wr_hit) begin
      ctrl_r <= i_req.wdata; // [R12]
    end
  end

  // Unmapped reads answer zero so the serial slave never sees stale data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= RDATA_IDLE;
      o_reg_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_reg_rvalid <= i_req.rd;
      o_reg_rdata  <= rd_hit ? ctrl_r : RDATA_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  wire open_loop_sel;
  wire hybrid_sel;
  wire ol_brake_en;
  wire idle_brake_en;
  wire slope_sel;

  assign open_loop_sel = ctrl_r[BIT_OPEN_LOOP];
  assign hybrid_sel    = ctrl_r[BIT_HYBRID];
  assign ol_brake_en   = ctrl_r[BIT_OL_BRAKE];
  assign idle_brake_en = ctrl_r[BIT_IDLE_BRAKE];
  assign slope_sel     = ctrl_r[BIT_SLOPE_CHK];

  ////////////////////////////////////////////////////////////////////////////
  // Loop selection

  logic play_nonpos_r;
  wire  play_nonpos;

  // Last played sample is held so the decision stays valid between samples
  assign play_nonpos = (i_play_data <= $signed({PLAY_W{1'b0}}));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      play_nonpos_r <= 1'b0;
    end else if (i_ce && i_play_valid) begin
      play_nonpos_r <= play_nonpos;
    end
  end

  wire closed_base;
  wire hybrid_eff;
  wire slope_eff;
  wire ol_brake_now;
  wire closed_nxt;

  // Hybrid and slope settings only mean something in closed loop
  assign closed_base  = !open_loop_sel; // [R1]
  assign hybrid_eff   = closed_base && hybrid_sel; // [R2]
  assign slope_eff    = hybrid_eff && slope_sel; // [R11]
  assign ol_brake_now = open_loop_sel && ol_brake_en && play_nonpos_r; // [R3] [R5]

  // Slope check keeps hybrid drive open until a big step is requested
  assign closed_nxt = ol_brake_now ? 1'b1 : // [R3]
                      open_loop_sel ? 1'b0 : // [R4]
                      slope_eff ? i_slope_big : // [R10]
                      1'b1; // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // Standby request sources

  logic pin_level;
  logic pin_level_d_r;

  // The pin is asynchronous, so it is filtered before any edge is taken
  pin_sync u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_pin   (i_trigger_or_irq_pin),
    .o_level (pin_level)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_level_d_r <= 1'b0;
    end else if (i_ce) begin
      pin_level_d_r <= pin_level;
    end
  end

  wire pin_fall;
  wire pin_release;
  wire idle_req;

  // In level-enable use the pin dropping low asks for standby
  assign pin_fall    = pin_level_d_r && !pin_level;
  assign pin_release = i_level_mode && pin_fall;
  assign idle_req    = i_timer_idle || pin_release; // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // Brake-before-standby sequencer

  pwr_state_t state_r;
  pwr_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PWR_RUN: begin
        if (idle_req) begin
          if (idle_brake_en && i_playing) begin
            state_nxt = PWR_CHECK; // [R7]
          end else begin
            state_nxt = PWR_STANDBY; // [R9]
          end
        end
      end
      PWR_CHECK: begin
        state_nxt = i_motion ? PWR_BRAKE : PWR_STANDBY; // [R8]
      end
      PWR_BRAKE: begin
        if (i_brake_done) begin
          state_nxt = PWR_STANDBY; // [R7]
        end
      end
      PWR_STANDBY: begin
        if (i_wake) begin
          state_nxt = PWR_RUN;
        end
      end
      default: begin
        // Unused codes fall back to the quiet state
        state_nxt = PWR_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // Start quiet: nothing is driven until a wake request
      state_r <= PWR_STANDBY;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  wire nxt_run;
  wire nxt_brake;
  wire nxt_standby;
  wire idle_braking;
  wire brake_nxt;

  assign nxt_run     = (state_nxt == PWR_RUN);
  assign nxt_brake   = (state_nxt == PWR_BRAKE);
  assign nxt_standby = (state_nxt == PWR_STANDBY);

  // Braking for standby always uses the closed loop, whatever is selected
  assign idle_braking = nxt_brake;
  assign brake_nxt    = idle_braking || (nxt_run && ol_brake_now); // [R3] [R8]

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_loop    <= '0;
      o_brake   <= 1'b0;
      o_standby <= 1'b1;
    end else if (i_ce) begin
      o_loop.closed_loop  <= closed_nxt || idle_braking;
      o_loop.hybrid       <= hybrid_eff;
      o_loop.slope_gate   <= slope_eff;
      o_loop.actuator_lra <= ctrl_r[BIT_ACT_LRA];
      o_brake             <= brake_nxt;
      o_standby           <= nxt_standby; // [R9]
    end
  end

endmodule : loop_brake_ctrl

// >>> hw/loop_brake_pkg.sv
// Constants, types and register layout of the loop and brake control block
// What this block does
// [R1] Loop-select bit: 0 closed loop, 1 open loop
// [R2] Hybrid bit: 0 full closed, 1 hybrid; resets 0
// [R3] Open-loop auto-brake: data <=0 closes loop, brakes
// [R4] Open-loop auto-brake: positive data stays open loop
// [R5] Open-loop auto-brake off after reset; 0 disables
// [R6] Host enables auto-brake only after closed-loop calibration
// [R7] Brake-before-idle: brake then standby on request
// [R8] Brake only if actuator moves, else standby directly
// [R9] Brake-before-idle cleared: standby at once, no brake
// [R10] Slope check: open loop unless change large enough
// [R11] Slope check ignored without hybrid; resets 0
// [R12] Two low bits reserved, read back, no effect
package loop_brake_pkg;

  localparam int         REG_W            = 8;
  localparam logic [7:0] LOOP_BRAKE_ADDR  = 8'h08;
  localparam logic [7:0] LOOP_BRAKE_RESET = 8'h88;
  localparam logic [7:0] RDATA_IDLE       = 8'h00;

  localparam int BIT_ACT_LRA    = 7;
  localparam int BIT_OPEN_LOOP  = 6;
  localparam int BIT_HYBRID     = 5;
  localparam int BIT_OL_BRAKE   = 4;
  localparam int BIT_IDLE_BRAKE = 3;
  localparam int BIT_SLOPE_CHK  = 2;

  localparam int PLAY_W = 8;

  // Register bus request from the serial slave logic on the same clock
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [7:0]       addr;
    logic [REG_W-1:0] wdata;
  } reg_req_t;

  // Drive-loop state handed to the actuator engine
  typedef struct packed {
    logic closed_loop;
    logic hybrid;
    logic slope_gate;
    logic actuator_lra;
  } loop_sel_t;

  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_CHECK   = 2'b01,
    PWR_BRAKE   = 2'b10,
    PWR_STANDBY = 2'b11
  } pwr_state_t;

endpackage : loop_brake_pkg

// >>> hw/pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
module pin_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // First stage feeds only the second; a change counts once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      o_level <= 1'b0;
    end else if (i_ce) begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end

endmodule : pin_sync

// >>> tb/loop_brake_chk.sv
// Concurrent checks on the loop and brake control ports
module loop_brake_chk
  import loop_brake_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire loop_brake_pkg::reg_req_t i_req,
  input wire logic [loop_brake_pkg::REG_W-1:0] o_reg_rdata,
  input wire logic i_play_valid,
  input wire logic signed [loop_brake_pkg::PLAY_W-1:0] i_play_data,
  input wire logic i_playing,
  input wire logic i_slope_big,
  input wire logic i_timer_idle,
  input wire logic i_motion,
  input wire loop_brake_pkg::loop_sel_t o_loop,
  input wire logic o_brake,
  input wire logic o_standby
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shadow of the control byte, so each check knows the mode in force
  logic [7:0] ctrl_r;
  wire        run = !o_standby && !o_brake;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) ctrl_r <= LOOP_BRAKE_RESET;
    else if (i_ce && i_req.wr && i_req.addr == LOOP_BRAKE_ADDR) ctrl_r <= i_req.wdata;
  end
  //////////////////////////////////////////////////////////////////////////////
  // A frozen clock enable holds everything, so checks pause with it
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);
  a_other_reads_zero: assert property (
    i_req.rd && i_req.addr != LOOP_BRAKE_ADDR |=> o_reg_rdata == RDATA_IDLE)
    else $error("unmapped read not zero");
  a_write_read_back: assert property (
    i_req.wr && i_req.addr == LOOP_BRAKE_ADDR ##1 i_req.rd && !i_req.wr &&
    i_req.addr == LOOP_BRAKE_ADDR |=> o_reg_rdata == $past(i_req.wdata, 2))
    else $error("control byte not read back");
  a_closed_select: assert property (
    !ctrl_r[6] && !(ctrl_r[5] && ctrl_r[2]) |=> o_loop.closed_loop)
    else $error("closed loop not chosen");
  a_open_select: assert property (
    ctrl_r[6] && !ctrl_r[4] && run |=> o_brake || !o_loop.closed_loop)
    else $error("open loop not chosen");
  a_slope_select: assert property (
    ctrl_r[6:5] == 2'b01 && ctrl_r[2] && run && !i_timer_idle
    |=> o_brake || o_loop.closed_loop == $past(i_slope_big))
    else $error("slope gate wrong");
  a_slope_ignored: assert property (
    !ctrl_r[5] |=> !o_loop.slope_gate)
    else $error("slope gate without hybrid");
  a_ol_brake: assert property (
    ctrl_r[6] && ctrl_r[4] && i_play_valid && !o_standby
    |-> ##2 o_brake == ($past(i_play_data, 2) <= 0))
    else $error("open loop brake wrong");
  a_idle_direct: assert property (
    i_timer_idle && run && !ctrl_r[3] |=> o_standby && !o_brake)
    else $error("standby not immediate");
  a_idle_brake: assert property (
    i_timer_idle && run && ctrl_r[3] && i_playing |=> !o_standby && !o_brake
    ##1 o_brake == $past(i_motion) && o_standby == !$past(i_motion))
    else $error("brake before standby wrong");
  c_brake_stby: cover property (o_brake ##1 !o_brake && o_standby);
  c_slope: cover property (o_loop.slope_gate);
  c_ol_brake: cover property (ctrl_r[4] && i_play_valid);
endmodule : loop_brake_chk

// >>> tb/actuator_model.sv
// Behavioural actuator: spins when kicked, stops after a braking spell
module actuator_model #(
  parameter int BRAKE_CYC = 5
) (
  input  wire logic i_clk,
  input  wire logic i_kick,
  input  wire logic i_brake,
  output logic      o_motion,
  output logic      o_brake_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial {o_motion, o_brake_done} = 2'b00;
  always @(posedge i_clk) begin
    n <= i_brake ? n + 1 : 0;
    o_brake_done <= i_brake && n == BRAKE_CYC - 1;
    if (i_kick) o_motion <= 1'b1;
    else if (o_brake_done) o_motion <= 1'b0;
  end
endmodule : actuator_model

// >>> tb/haptic_loop_brake_control_tb_top.sv
// Self-checking bench for the loop and brake control block
module haptic_loop_brake_control_tb_top
  import loop_brake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_play_valid = 0, i_playing = 0;
  logic i_slope_big = 0, i_timer_idle = 0, i_trigger_or_irq_pin = 1;
  logic i_level_mode = 0, i_wake = 0, kick = 0, b;
  logic signed [PLAY_W-1:0] i_play_data = '0;
  reg_req_t i_req = '0;
  logic [REG_W-1:0] o_reg_rdata, v;
  logic o_reg_rvalid, o_brake, o_standby, i_motion, i_brake_done;
  loop_sel_t o_loop;
  int fail_count = 0, num_checks = 0, mdl, k;
  int smp[$] = '{0, 9, -3, 127, -128, 1};
  logic [7:0] cfg[$] = '{8'h80, 8'h04, 8'h20, 8'h24, 8'h24, 8'h40, 8'h64};
  always #2 i_clk = ~i_clk;
  loop_brake_ctrl i_loop_brake_ctrl (
    .i_clk                (i_clk),
    .i_rst_n              (i_rst_n),
    .i_ce                 (i_ce),
    .i_req                (i_req),
    .o_reg_rdata          (o_reg_rdata),
    .o_reg_rvalid         (o_reg_rvalid),
    .i_play_valid         (i_play_valid),
    .i_play_data          (i_play_data),
    .i_playing            (i_playing),
    .i_slope_big          (i_slope_big),
    .i_timer_idle         (i_timer_idle),
    .i_trigger_or_irq_pin (i_trigger_or_irq_pin),
    .i_level_mode         (i_level_mode),
    .i_wake               (i_wake),
    .i_motion             (i_motion),
    .i_brake_done         (i_brake_done),
    .o_loop               (o_loop),
    .o_brake              (o_brake),
    .o_standby            (o_standby)
  );
  actuator_model i_actuator_model (.i_clk(i_clk), .i_kick(kick), .i_brake(o_brake),
    .o_motion(i_motion), .o_brake_done(i_brake_done));
  //////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  // Request stays up for the next call, so chained accesses run back to back
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    i_req = '{w, r, a, d};
    cyc(1);
    chk(o_reg_rvalid, r);
    if (r) chk(o_reg_rdata, a == LOOP_BRAKE_ADDR ? mdl[7:0] : RDATA_IDLE);
    if (w && a == LOOP_BRAKE_ADDR) mdl = d;
  endtask : bus
  task automatic play(input int s);
    i_play_data = 8'(s);
    i_play_valid = 1;
    cyc(1);
    i_play_valid = 0;
    cyc(2);
  endtask : play
  // Standby request from the timer, or from the pin falling in level-enable use
  task automatic stby(input logic pin, output int n, output logic bb);
    if (pin) i_trigger_or_irq_pin = 0;
    else i_timer_idle = 1;
    cyc(1);
    i_timer_idle = 0;
    bb = 0;
    for (n = 0; n < 50; n++) begin
      if (o_standby) return;
      bb |= o_brake;
      cyc(1);
    end
    fail_count++;
    results();
  endtask : stby
  task automatic wake;
    i_wake = 1;
    cyc(1);
    i_wake = 0;
    cyc(1);
  endtask : wake
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8258));
    cyc(12);
    i_rst_n = 1;
    mdl = LOOP_BRAKE_RESET;
    bus(0, 1, LOOP_BRAKE_ADDR, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      bus(1, 0, 8'h07, ~v);
      bus(1, 0, LOOP_BRAKE_ADDR, v);
      bus(1, 1, LOOP_BRAKE_ADDR, ~v);
      bus(0, 1, LOOP_BRAKE_ADDR, 8'h00);
      bus(0, 1, v, 8'h00);
    end
    i_req = '0;
    wake();
    foreach (cfg[i]) begin
      i_slope_big = 1'($urandom);
      bus(1, 0, LOOP_BRAKE_ADDR, cfg[i]);
      i_req = '0;
      cyc(2);
      chk(o_loop.closed_loop, cfg[i][6] ? 0 : cfg[i][5] && cfg[i][2] ? i_slope_big : 1);
      chk(o_loop.slope_gate, cfg[i][5] && cfg[i][2] && !cfg[i][6]);
      chk(o_loop.hybrid, cfg[i][5] && !cfg[i][6]);
      chk(o_loop.actuator_lra, cfg[i][7]);
    end
    bus(1, 0, LOOP_BRAKE_ADDR, 8'h50);
    i_req = '0;
    foreach (smp[i]) begin
      play(smp[i]);
      chk(o_brake, smp[i] <= 0);
      chk(o_loop.closed_loop, smp[i] <= 0);
    end
    bus(1, 0, LOOP_BRAKE_ADDR, 8'h40);
    i_req = '0;
    play(-1);
    chk(o_brake, 0);
    bus(1, 0, LOOP_BRAKE_ADDR, 8'h08);
    i_req = '0;
    i_playing = 1;
    kick = 1;
    cyc(1);
    kick = 0;
    stby(0, k, b);
    chk(b, 1);
    wake();
    stby(0, k, b);
    chk(b, 0);
    wake();
    bus(1, 0, LOOP_BRAKE_ADDR, 8'h00);
    i_req = '0;
    stby(0, k, b);
    chk(8'(k), 0);
    chk(b, 0);
    wake();
    bus(1, 0, LOOP_BRAKE_ADDR, 8'h08);
    i_req = '0;
    i_level_mode = 1;
    kick = 1;
    cyc(1);
    kick = 0;
    stby(1, k, b);
    chk(b, 1);
    results();
  end
endmodule : haptic_loop_brake_control_tb_top
bind loop_brake_ctrl loop_brake_chk i_loop_brake_chk (
  .i_clk        (i_clk),
  .i_rst_n      (i_rst_n),
  .i_ce         (i_ce),
  .i_req        (i_req),
  .o_reg_rdata  (o_reg_rdata),
  .i_play_valid (i_play_valid),
  .i_play_data  (i_play_data),
  .i_playing    (i_playing),
  .i_slope_big  (i_slope_big),
  .i_timer_idle (i_timer_idle),
  .i_motion     (i_motion),
  .o_loop       (o_loop),
  .o_brake      (o_brake),
  .o_standby    (o_standby)
);
